// [design/ipl_pkg.sv]
/*
  ipl_pkg: offsets, field positions, reset values and carrier types for the
  interrupt priority level block.
  assumes: an 8-bit special-function register space reached over a plain port.
*/
package ipl_pkg;

  // register offsets
  localparam logic [7:0] IPL_OFS_LOW_B  = 8'hb2;
  localparam logic [7:0] IPL_OFS_HIGH_B = 8'hb3;
  localparam logic [7:0] IPL_OFS_HIGH_A = 8'hb7;
  localparam logic [7:0] IPL_OFS_LOW_A  = 8'hb8;

  // reset values
  localparam logic [7:0] IPL_RST_VAL    = 8'h00;

  // bank b: bits 6 and 3 are reserved
  localparam logic [7:0] IPL_BANK_B_MASK = 8'hb7;

  // level block bit position, common to all four registers
  localparam int IPL_BLOCK_BIT = 7;

  // source counts
  localparam int IPL_SRC_A = 7;
  localparam int IPL_SRC_B = 6;
  localparam int IPL_SRC_N = IPL_SRC_A + IPL_SRC_B;

  // source index in the combined vector (bank a low, bank b above)
  localparam int IPL_SRC_EXT_ZERO   = 0;
  localparam int IPL_SRC_TIMER_ZERO = 1;
  localparam int IPL_SRC_EXT_ONE    = 2;
  localparam int IPL_SRC_TIMER_ONE  = 3;
  localparam int IPL_SRC_SERIAL     = 4;
  localparam int IPL_SRC_TIMER_TWO  = 5;
  localparam int IPL_SRC_COUNTER    = 6;
  localparam int IPL_SRC_KEYPAD     = 7;
  localparam int IPL_SRC_TWO_WIRE   = 8;
  localparam int IPL_SRC_SPI        = 9;
  localparam int IPL_SRC_RSVD_B3    = 10;
  localparam int IPL_SRC_COMPARATOR = 11;
  localparam int IPL_SRC_CONVERTER  = 12;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ipl_bus_req_t;

  // per-source level
  typedef logic [1:0] ipl_level_t;

endpackage

// [design/ipl_top.sv]
/*
  ipl_top: priority level registers, per-source two-bit levels and the
  per-level block mask for the interrupt controller.
  assumes: the register master follows one-cycle strobes and reads data in the
  cycle after the read strobe; source enables and global enable come from the
  enable registers on the same clock.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module ipl_top
  import ipl_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   resetn_in,
  // register port
  input  wire ipl_pkg::ipl_bus_req_t  bus_req_in,
  output logic [7:0]                  bus_rdata_out,
  // sources
  input  wire logic [ipl_pkg::IPL_SRC_N-1:0] src_enable_in,
  input  wire logic                   global_irq_enable_in,
  // priority results
  output logic [2*ipl_pkg::IPL_SRC_N-1:0]    src_level_out,
  output logic [ipl_pkg::IPL_SRC_N-1:0]      src_eligible_out,
  output logic [3:0]                  level_block_out
);
  import ipl_pkg::*;

  logic [7:0] priority_low_bank_a;
  logic [7:0] priority_high_bank_a;
  logic [7:0] priority_low_bank_b;
  logic [7:0] priority_high_bank_b;
  logic [IPL_SRC_N-1:0] hi_bits;
  logic [IPL_SRC_N-1:0] lo_bits;
  logic [7:0] next_rdata;
  logic [7:0] wdata_b;
  logic [2*IPL_SRC_N-1:0] next_level;
  logic [IPL_SRC_N-1:0] next_eligible;

  // named fields of the four registers
  logic level_zero_block;
  logic level_one_block;
  logic level_two_block;
  logic level_three_block;
  logic counter_array_prio_lo;
  logic timer_two_prio_lo;
  logic serial_prio_lo;
  logic timer_one_prio_lo;
  logic ext_one_prio_lo;
  logic timer_zero_prio_lo;
  logic ext_zero_prio_lo;
  logic counter_array_prio_hi;
  logic timer_two_prio_hi;
  logic serial_prio_hi;
  logic timer_one_prio_hi;
  logic ext_one_prio_hi;
  logic timer_zero_prio_hi;
  logic ext_zero_prio_hi;
  logic converter_prio_lo;
  logic comparator_prio_lo;
  logic spi_prio_lo;
  logic two_wire_prio_lo;
  logic keypad_prio_lo;
  logic converter_prio_hi;
  logic comparator_prio_hi;
  logic spi_prio_hi;
  logic two_wire_prio_hi;
  logic keypad_prio_hi;

  // bank b drops its reserved bits before they reach the flops
  assign wdata_b = bus_req_in.wdata & IPL_BANK_B_MASK;

  // write decode; unmapped offsets are ignored
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      priority_low_bank_a  <= IPL_RST_VAL;
      priority_high_bank_a <= IPL_RST_VAL;
      priority_low_bank_b  <= IPL_RST_VAL;
      priority_high_bank_b <= IPL_RST_VAL;
    end else if (bus_req_in.wr) begin
      unique case (bus_req_in.addr)
        IPL_OFS_LOW_A:  priority_low_bank_a  <= bus_req_in.wdata;
        IPL_OFS_HIGH_A: priority_high_bank_a <= bus_req_in.wdata;
        IPL_OFS_LOW_B:  priority_low_bank_b  <= wdata_b;
        IPL_OFS_HIGH_B: priority_high_bank_b <= wdata_b;
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req_in.rd) begin
      unique case (bus_req_in.addr)
        IPL_OFS_LOW_A:  next_rdata = priority_low_bank_a;
        IPL_OFS_HIGH_A: next_rdata = priority_high_bank_a;
        IPL_OFS_LOW_B:  next_rdata = priority_low_bank_b;
        IPL_OFS_HIGH_B: next_rdata = priority_high_bank_b;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_rdata_out <= 8'h00;
    end else begin
      bus_rdata_out <= next_rdata;
    end
  end

  // low bank a: low bits of bank-a sources, bit 7 blocks level zero
  assign level_zero_block      = priority_low_bank_a[IPL_BLOCK_BIT];
  assign counter_array_prio_lo = priority_low_bank_a[IPL_SRC_COUNTER];
  assign timer_two_prio_lo     = priority_low_bank_a[IPL_SRC_TIMER_TWO];
  assign serial_prio_lo        = priority_low_bank_a[IPL_SRC_SERIAL];
  assign timer_one_prio_lo     = priority_low_bank_a[IPL_SRC_TIMER_ONE];
  assign ext_one_prio_lo       = priority_low_bank_a[IPL_SRC_EXT_ONE];
  assign timer_zero_prio_lo    = priority_low_bank_a[IPL_SRC_TIMER_ZERO];
  assign ext_zero_prio_lo      = priority_low_bank_a[IPL_SRC_EXT_ZERO];

  // high bank a: high bits of bank-a sources, bit 7 blocks level one
  assign level_one_block       = priority_high_bank_a[IPL_BLOCK_BIT];
  assign counter_array_prio_hi = priority_high_bank_a[IPL_SRC_COUNTER];
  assign timer_two_prio_hi     = priority_high_bank_a[IPL_SRC_TIMER_TWO];
  assign serial_prio_hi        = priority_high_bank_a[IPL_SRC_SERIAL];
  assign timer_one_prio_hi     = priority_high_bank_a[IPL_SRC_TIMER_ONE];
  assign ext_one_prio_hi       = priority_high_bank_a[IPL_SRC_EXT_ONE];
  assign timer_zero_prio_hi    = priority_high_bank_a[IPL_SRC_TIMER_ZERO];
  assign ext_zero_prio_hi      = priority_high_bank_a[IPL_SRC_EXT_ZERO];

  // low bank b: bank-b sources sit at their index less the bank-a count
  assign level_two_block    = priority_low_bank_b[IPL_BLOCK_BIT];
  assign converter_prio_lo  = priority_low_bank_b[IPL_SRC_CONVERTER-IPL_SRC_A];
  assign comparator_prio_lo = priority_low_bank_b[IPL_SRC_COMPARATOR-IPL_SRC_A];
  assign spi_prio_lo        = priority_low_bank_b[IPL_SRC_SPI-IPL_SRC_A];
  assign two_wire_prio_lo   = priority_low_bank_b[IPL_SRC_TWO_WIRE-IPL_SRC_A];
  assign keypad_prio_lo     = priority_low_bank_b[IPL_SRC_KEYPAD-IPL_SRC_A];

  // high bank b: bit 7 blocks level three
  assign level_three_block  = priority_high_bank_b[IPL_BLOCK_BIT];
  assign converter_prio_hi  = priority_high_bank_b[IPL_SRC_CONVERTER-IPL_SRC_A];
  assign comparator_prio_hi = priority_high_bank_b[IPL_SRC_COMPARATOR-IPL_SRC_A];
  assign spi_prio_hi        = priority_high_bank_b[IPL_SRC_SPI-IPL_SRC_A];
  assign two_wire_prio_hi   = priority_high_bank_b[IPL_SRC_TWO_WIRE-IPL_SRC_A];
  assign keypad_prio_hi     = priority_high_bank_b[IPL_SRC_KEYPAD-IPL_SRC_A];

  // high bits by source index; the reserved slot is tied to level zero
  assign hi_bits[IPL_SRC_EXT_ZERO]   = ext_zero_prio_hi;
  assign hi_bits[IPL_SRC_TIMER_ZERO] = timer_zero_prio_hi;
  assign hi_bits[IPL_SRC_EXT_ONE]    = ext_one_prio_hi;
  assign hi_bits[IPL_SRC_TIMER_ONE]  = timer_one_prio_hi;
  assign hi_bits[IPL_SRC_SERIAL]     = serial_prio_hi;
  assign hi_bits[IPL_SRC_TIMER_TWO]  = timer_two_prio_hi;
  assign hi_bits[IPL_SRC_COUNTER]    = counter_array_prio_hi;
  assign hi_bits[IPL_SRC_KEYPAD]     = keypad_prio_hi;
  assign hi_bits[IPL_SRC_TWO_WIRE]   = two_wire_prio_hi;
  assign hi_bits[IPL_SRC_SPI]        = spi_prio_hi;
  assign hi_bits[IPL_SRC_RSVD_B3]    = 1'b0;
  assign hi_bits[IPL_SRC_COMPARATOR] = comparator_prio_hi;
  assign hi_bits[IPL_SRC_CONVERTER]  = converter_prio_hi;

  // low bits by source index, same order as the high bits
  assign lo_bits[IPL_SRC_EXT_ZERO]   = ext_zero_prio_lo;
  assign lo_bits[IPL_SRC_TIMER_ZERO] = timer_zero_prio_lo;
  assign lo_bits[IPL_SRC_EXT_ONE]    = ext_one_prio_lo;
  assign lo_bits[IPL_SRC_TIMER_ONE]  = timer_one_prio_lo;
  assign lo_bits[IPL_SRC_SERIAL]     = serial_prio_lo;
  assign lo_bits[IPL_SRC_TIMER_TWO]  = timer_two_prio_lo;
  assign lo_bits[IPL_SRC_COUNTER]    = counter_array_prio_lo;
  assign lo_bits[IPL_SRC_KEYPAD]     = keypad_prio_lo;
  assign lo_bits[IPL_SRC_TWO_WIRE]   = two_wire_prio_lo;
  assign lo_bits[IPL_SRC_SPI]        = spi_prio_lo;
  assign lo_bits[IPL_SRC_RSVD_B3]    = 1'b0;
  assign lo_bits[IPL_SRC_COMPARATOR] = comparator_prio_lo;
  assign lo_bits[IPL_SRC_CONVERTER]  = converter_prio_lo;

  // per-level block bits, index is the level number
  assign level_block_out = {level_three_block,
                            level_two_block,
                            level_one_block,
                            level_zero_block};

  // next level and eligibility per source
  // level 0 is both bits clear, level 3 both set; the high bit weighs more
  // the reserved slot always lands on level 0 and follows its block bit
  genvar g;
  generate
    for (g = 0; g < IPL_SRC_N; g++) begin : g_src
      ipl_level_t lvl;
      assign lvl                   = {hi_bits[g], lo_bits[g]};
      assign next_level[2*g+1:2*g] = lvl;
      // a blocked level hides the source no matter its enable
      assign next_eligible[g] = src_enable_in[g] & global_irq_enable_in
                                & ~level_block_out[lvl];
    end
  endgenerate

  // one flop bank for all sources, so each output has a single driver
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      src_level_out    <= '0;
      src_eligible_out <= '0;
    end else begin
      src_level_out    <= next_level;
      src_eligible_out <= next_eligible;
    end
  end

endmodule

`default_nettype wire

// [verif/ipl_monitor.sv]
/* ipl_monitor: port assertions for ipl_top.
   assumes: bound onto ipl_top, single clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module ipl_monitor
  import ipl_pkg::*;
(
  // clock, reset, bus
  input wire logic                 sys_clk_in,
  input wire logic                 resetn_in,
  input wire ipl_pkg::ipl_bus_req_t bus_req_in,
  input wire logic [7:0]           bus_rdata_out,
  // sources and results
  input wire logic [12:0]          src_enable_in,
  input wire logic                 global_irq_enable_in,
  input wire logic [25:0]          src_level_out,
  input wire logic [12:0]          src_eligible_out,
  input wire logic [3:0]           level_block_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // one write strobe to a given offset
  sequence s_wr(logic [7:0] ad);
    bus_req_in.wr && bus_req_in.addr == ad;
  endsequence

  // one read strobe to low bank b
  sequence s_rd_low_b;
    bus_req_in.rd && bus_req_in.addr == IPL_OFS_LOW_B;
  endsequence

  // levels and block bits come out of reset cleared
  property p_rst;
    $rose(resetn_in) |-> level_block_out == 4'h0 && src_level_out == 26'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");

  // each block bit follows bit 7 of its register one cycle after the write
  property p_b3;
    s_wr(IPL_OFS_HIGH_B) |=> level_block_out[3] == $past(bus_req_in.wdata[7]);
  endproperty
  a_b3: assert property (p_b3) else $error("level three block wrong");
  property p_b7;
    s_wr(IPL_OFS_HIGH_A) |=> level_block_out[1] == $past(bus_req_in.wdata[7]);
  endproperty
  a_b7: assert property (p_b7) else $error("level one block wrong");
  property p_b2;
    s_wr(IPL_OFS_LOW_B) |=> level_block_out[2] == $past(bus_req_in.wdata[7]);
  endproperty
  a_b2: assert property (p_b2) else $error("level two block wrong");
  property p_b8;
    s_wr(IPL_OFS_LOW_A) |=> level_block_out[0] == $past(bus_req_in.wdata[7]);
  endproperty
  a_b8: assert property (p_b8) else $error("level zero block wrong");

  // levels reach the outputs one cycle behind the registers
  property p_lvl;
    s_wr(IPL_OFS_HIGH_B) |-> ##2 src_level_out[15] == $past(bus_req_in.wdata[0], 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("keypad high level bit wrong");
  property p_lvl_lo;
    s_wr(IPL_OFS_LOW_B) |-> ##2 src_level_out[14] == $past(bus_req_in.wdata[0], 2);
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("keypad low level bit wrong");

  // reserved low-bank-b bits never read back as one
  property p_rsv;
    s_rd_low_b |=> !bus_rdata_out[6] && !bus_rdata_out[3];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");

  // no source is eligible one cycle after the global enable was low
  property p_elig;
    !$past(global_irq_enable_in) |-> src_eligible_out == 13'h0;
  endproperty
  a_elig: assert property (p_elig) else $error("eligible without global enable");
endmodule
bind ipl_top ipl_monitor u_mon (.*);
`default_nettype wire

// [verif/tb.sv]
/* tb: random register traffic against a bench model of the priority registers.
   assumes: ipl_top and ipl_pkg compiled before this file. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ipl_pkg::*;
  logic sys_clk_in = 0, resetn_in = 0, g = 0;
  ipl_bus_req_t rq = '0;
  logic [12:0] en = '0, el;
  logic [7:0] rdat, d, m[256] = '{default: 8'h00}, ads[5] = '{8'hb2, 8'hb3, 8'hb7, 8'hb8, 8'hb4};
  logic [25:0] lv;
  logic [3:0] bk;
  int fails = 0, n_checks = 0, cyc = 0;
  ipl_top dut_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .bus_req_in(rq),
    .bus_rdata_out(rdat), .src_enable_in(en), .global_irq_enable_in(g),
    .src_level_out(lv), .src_eligible_out(el), .level_block_out(bk));
  always #12.5 sys_clk_in = ~sys_clk_in;
  // hang guard, far above the roughly 1100 cycles the tests take
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      results();
    end
  end
  task automatic results;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // model keeps only writable bits; unmapped offsets stay zero
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a == IPL_OFS_LOW_B || a == IPL_OFS_HIGH_B) return IPL_BANK_B_MASK;
    if (a == IPL_OFS_LOW_A || a == IPL_OFS_HIGH_A) return 8'hff;
    return 8'h00;
  endfunction
  function automatic logic [25:0] lvx();
    for (int i = 0; i < 13; i++)
      lvx[2*i+:2] = i < 7 ? {m[8'hb7][i], m[8'hb8][i]} : {m[8'hb3][i-7], m[8'hb2][i-7]};
  endfunction
  function automatic logic [12:0] elx(input logic [3:0] b);
    logic [25:0] l;
    l = lvx();
    for (int i = 0; i < 13; i++) elx[i] = en[i] & g & ~b[l[2*i+:2]];
  endfunction
  // an idle edge after the strobe keeps rq from being set twice in one step
  task automatic wr(input logic [7:0] a, dt);
    rq <= '{a, dt, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    rq.wr <= 1'b0;
    m[a] = dt & msk(a);
    @(posedge sys_clk_in);
  endtask
  // read data is looked at once the taking edge has settled
  task automatic rd(input logic [7:0] a);
    rq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    rq.rd <= 1'b0;
    #1 chk(rdat, m[a]);
    @(posedge sys_clk_in);
  endtask
  task automatic outs;
    logic [3:0] b;
    b = {m[8'hb3][7], m[8'hb2][7], m[8'hb7][7], m[8'hb8][7]};
    #1 chk(lv, lvx());
    chk(bk, b);
    chk(el, elx(b));
    @(posedge sys_clk_in);
  endtask
  initial begin
    void'($urandom(13571));
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    foreach (ads[k]) rd(ads[k]);
    outs();
    $display("test reset values done");
    foreach (ads[k]) wr(ads[k], 8'hff);
    en <= '1;
    g <= 1'b1;
    foreach (ads[k]) rd(ads[k]);
    outs();
    $display("test all ones done");
    repeat (200) begin
      d = 8'($urandom);
      wr(ads[$urandom % 5], d);
      en <= 13'($urandom);
      g <= 1'($urandom);
      rd(ads[$urandom % 5]);
      outs();
    end
    $display("test random traffic done");
    // a mid-run reset must clear what the traffic left behind
    foreach (ads[k]) wr(ads[k], 8'hff);
    resetn_in <= 1'b0;
    @(posedge sys_clk_in);
    foreach (m[k]) m[k] = 8'h00;
    @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    foreach (ads[k]) rd(ads[k]);
    outs();
    $display("test mid-run reset done");
    results();
  end
endmodule
`default_nettype wire
